// file: src/tmlam_pkg.sv
// Purpose: shared constants for the temperature monitor and limit alarm core
// Assumes: 100 MHz core clock, 8-bit registers on 32-bit AXI4-Lite words
// Notes:   register byte address is four times the register index
package tmlam_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SMB_TIMEOUT_MS  = 25;
  // typical wait rounds down to whole cycles
  localparam int unsigned SMB_TIMEOUT_CYC = (CLK_HZ / 1000) * SMB_TIMEOUT_MS;
  localparam int unsigned SMB_TIMEOUT_MAX_MS = 300;
  localparam int unsigned CONV_BASE_CYC   = 1000;

  // register indices, byte address = index * 4
  localparam logic [7:0] REG_LOCAL      = 8'h00;
  localparam logic [7:0] REG_REMOTE_HI  = 8'h01;
  localparam logic [7:0] REG_STATUS     = 8'h02;
  localparam logic [7:0] REG_CONFIG     = 8'h03;
  localparam logic [7:0] REG_RATE       = 8'h04;
  localparam logic [7:0] REG_LIMIT_BASE = 8'h05;
  localparam logic [7:0] REG_LIMIT_LAST = 8'h0C;
  localparam logic [7:0] REG_REMOTE_LO  = 8'h10;

  // limit slots, offset from REG_LIMIT_BASE
  localparam int unsigned LIM_L_HIGH = 0;
  localparam int unsigned LIM_L_LOW  = 1;
  localparam int unsigned LIM_R_HIGH = 2;
  localparam int unsigned LIM_R_LOW  = 3;
  localparam int unsigned LIM_L_TRIP = 4;
  localparam int unsigned LIM_R_TRIP = 5;
  localparam int unsigned LIM_R_HIGH_FRAC = 6;
  localparam int unsigned LIM_R_LOW_FRAC  = 7;
  localparam int unsigned LIM_COUNT  = 8;

  // configuration bits
  localparam int unsigned CFG_ALARM_MASK = 7;
  localparam int unsigned CFG_STANDBY    = 6;
  localparam int unsigned CFG_PIN_TRIP2  = 5;
  localparam int unsigned CFG_EXT_RANGE  = 2;
  localparam int unsigned CFG_TIMEOUT_EN = 0;

  // status bits
  localparam int unsigned ST_BUSY   = 7;
  localparam int unsigned ST_L_HIGH = 6;
  localparam int unsigned ST_L_LOW  = 5;
  localparam int unsigned ST_R_HIGH = 4;
  localparam int unsigned ST_R_LOW  = 3;
  localparam int unsigned ST_FAULT  = 2;
  localparam int unsigned ST_R_TRIP = 1;
  localparam int unsigned ST_L_TRIP = 0;

  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_RATE   = 8'h08;
  localparam logic [7:0] RST_HIGH   = 8'h55;
  localparam logic [7:0] RST_LOW    = 8'h00;
  localparam logic [7:0] RST_TRIP   = 8'h55;
  localparam logic [7:0] RST_FRAC   = 8'h00;
  localparam logic [3:0] RATE_MAX   = 4'hA;

  // result clamps in quarter degrees, extended offset of 64 degrees
  localparam logic signed [10:0] QD_MIN_DEF = 11'sh000;
  localparam logic signed [10:0] QD_MIN_EXT = -11'sh0A0;
  localparam logic signed [10:0] QD_MAX     = 11'sh1F4;
  localparam logic signed [10:0] QD_OFFSET  = 11'sh100;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: src/tmlam_sync.sv
// Purpose: two-stage synchroniser for pins entering the core clock
// Assumes: inputs are slow levels relative to clk_i
// Notes:   only the second stage may be read by logic
`timescale 1ns/100ps
`default_nettype none
module tmlam_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } tmlam_sync_state_type;

  tmlam_sync_state_type s_q, s_d;

  initial begin
    if (WIDTH < 1) $error("tmlam_sync: WIDTH must be at least 1");
  end

  // first stage feeds only the second
  always_comb begin
    s_d        = s_q;
    s_d.meta   = async_i ^ rst_val_i;
    s_d.stable = s_q.meta;
  end

  // reset to constants; rst_val_i applies through the output xor, in reset as well
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // stages hold pin xor rst_val_i, so a cleared flop reads as rst_val_i
  assign sync_o = s_q.stable ^ rst_val_i;
endmodule
`default_nettype wire

// file: src/tmlam_axil.sv
// Purpose: AXI4-Lite slave turning bus traffic into register strokes
// Assumes: one write and one read outstanding at most
// Notes:   write strobe and read strobe each last one cycle
`timescale 1ns/100ps
`default_nettype none
module tmlam_axil (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_en_o,
  output logic [31:0]      wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic             wr_byte0_o,
  input  wire logic        wr_ok_i,
  output logic             rd_en_o,
  output logic [31:0]      rd_addr_o,
  input  wire logic [7:0]  rd_data_i,
  input  wire logic        rd_ok_i
);
  typedef struct packed {
    logic        aw_have;
    logic [31:0] awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic        wbyte0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        ar_have;
    logic [31:0] araddr;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tmlam_axil_state_type;

  tmlam_axil_state_type s_q, s_d;

  // write once both halves are held and no response is pending
  assign wr_en_o    = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
  assign wr_addr_o  = s_q.awaddr;
  assign wr_data_o  = s_q.wdata;
  assign wr_byte0_o = s_q.wbyte0;
  assign rd_en_o    = s_q.ar_have & ~s_q.rvalid;
  assign rd_addr_o  = s_q.araddr;

  // channel handshakes, address and data taken in either order
  always_comb begin
    s_d = s_q;
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wbyte0 = s_axi_wstrb[0];
    end
    if (wr_en_o) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = wr_ok_i ? tmlam_pkg::RESP_OKAY : tmlam_pkg::RESP_SLVERR;
    end else if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = ~s_d.aw_have & ~s_d.bvalid;
    s_d.wready  = ~s_d.w_have & ~s_d.bvalid;
    if (s_axi_arvalid && s_q.arready) begin
      s_d.ar_have = 1'b1;
      s_d.araddr  = s_axi_araddr;
    end
    if (rd_en_o) begin
      s_d.ar_have = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = {24'h000000, rd_data_i};
      s_d.rresp   = rd_ok_i ? tmlam_pkg::RESP_OKAY : tmlam_pkg::RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = ~s_d.ar_have & ~s_d.rvalid;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
endmodule
`default_nettype wire

// file: src/tmlam_top.sv
// Purpose: conversion sequencer, result registers, limit checks and alarm pins
// Assumes: converter front end on clk_i; smbus clock and fault are pins
// Notes:   registers reached over AXI4-Lite, one 8-bit register per word
`timescale 1ns/100ps
`default_nettype none
// Contract
// (R1) converter restarts conversions by itself while running normally
// (R2) conversions alternate between local and remote sensors
// (R3) each result lands in its own channel's value register
// (R4) results compared against high, low and trip limits in eight registers
// (R5) any out-of-limit comparison sets its status flag
// (R6) alarm asserts low on high or low limit violation
// (R7) alarm also asserts on external sensor connection fault
// (R8) trip output goes low when a result exceeds its trip limit
// (R9) configuration can turn the alarm pin into a second trip output
// (R10) host writes limits and configuration, device updates control state
// (R11) host can read back every register
// (R12) config: standby, range, alarm mask, pin function, conversion rate
// (R13) bus timeout, 25 ms typical, disabled until host enables it
// (R14) config bit 2 selects extended range, clear gives 0 to 125
// (R15) extended range reports offset binary shifted by 64 degrees
// (R16) reading remote low byte freezes high byte until it is read
// (R17) masked alarm still records flags but keeps the pin released
module tmlam_top #(
  parameter int unsigned CONV_BASE_CYCLES = tmlam_pkg::CONV_BASE_CYC,
  parameter int unsigned SMB_TIMEOUT_CYCLES = tmlam_pkg::SMB_TIMEOUT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             conv_start_o,
  output logic             conv_remote_o,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_data_i,
  input  wire logic        sensor_fault_i,
  input  wire logic        smbus_scl_i,
  output logic             smbus_timeout_o,
  output logic             alarm_n_o,
  output logic             alarm_oe_o,
  output logic             thermal_trip_n_o,
  output logic             thermal_trip_oe_o
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_WAIT  = 3'b100
  } tmlam_conv_state_type;

  typedef struct packed {
    tmlam_conv_state_type      conv;
    logic [31:0]               timer;
    logic                      remote;
    logic [7:0]                local_val;
    logic [7:0]                rem_hi;
    logic [7:0]                rem_lo;
    logic                      hi_lock;
    logic [7:0]                status;
    logic [7:0]                config_r;
    logic [7:0]                rate;
    logic [tmlam_pkg::LIM_COUNT-1:0][7:0] limit;
    logic                      trip_l;
    logic                      trip_r;
    logic                      conv_start;
    logic [31:0]               smb_cnt;
    logic                      smb_to;
    logic                      alarm_n;
    logic                      trip_n;
  } tmlam_top_state_type;

  tmlam_top_state_type s_q, s_d;

  logic        wr_en, wr_byte0, rd_en, rd_ok, wr_ok, fault_s, scl_s;
  logic [31:0] wr_addr, wr_data, rd_addr;
  logic [7:0]  rd_data;
  logic [1:0]  pins_sync;

  initial begin
    if (CONV_BASE_CYCLES < 1 || CONV_BASE_CYCLES > 32'h0040_0000)
      $error("tmlam_top: CONV_BASE_CYCLES out of range");
    if (SMB_TIMEOUT_CYCLES < 2)
      $error("tmlam_top: SMB_TIMEOUT_CYCLES too small");
  end

  tmlam_axil u_axil (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en_o       (wr_en),
    .wr_addr_o     (wr_addr),
    .wr_data_o     (wr_data),
    .wr_byte0_o    (wr_byte0),
    .wr_ok_i       (wr_ok),
    .rd_en_o       (rd_en),
    .rd_addr_o     (rd_addr),
    .rd_data_i     (rd_data),
    .rd_ok_i       (rd_ok)
  );

  // scl idles high, so its synchronised value reads high from reset on
  tmlam_sync #(.WIDTH(2)) u_sync (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({smbus_scl_i, sensor_fault_i}),
    .rst_val_i (2'h2),
    .sync_o    (pins_sync)
  );
  assign fault_s = pins_sync[0];
  assign scl_s   = pins_sync[1];

  // map a byte address to its register index, flag unmapped ones
  function automatic logic mapped(input logic [31:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    mapped = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0) &&
             (idx <= tmlam_pkg::REG_LIMIT_LAST || idx == tmlam_pkg::REG_REMOTE_LO);
  endfunction

  // clamp raw quarter degrees and encode for the chosen range
  function automatic logic [9:0] encode(input logic [9:0] raw, input logic ext);
    logic signed [10:0] v;
    v = {raw[9], raw};
    // (R14) range select clamp
    if (ext && v < tmlam_pkg::QD_MIN_EXT) v = tmlam_pkg::QD_MIN_EXT;
    if (!ext && v < tmlam_pkg::QD_MIN_DEF) v = tmlam_pkg::QD_MIN_DEF;
    if (v > tmlam_pkg::QD_MAX) v = tmlam_pkg::QD_MAX;
    // (R15) offset binary shift
    if (ext) v = v + tmlam_pkg::QD_OFFSET;
    encode = v[9:0];
  endfunction

  assign wr_ok = mapped(wr_addr);
  assign rd_ok = mapped(rd_addr);

  // (R11) read mux over every register
  always_comb begin
    rd_data = 8'h00;
    case (rd_addr[9:2])
      tmlam_pkg::REG_LOCAL:     rd_data = s_q.local_val;
      tmlam_pkg::REG_REMOTE_HI: rd_data = s_q.rem_hi;
      tmlam_pkg::REG_REMOTE_LO: rd_data = s_q.rem_lo;
      tmlam_pkg::REG_STATUS:    rd_data = s_q.status;
      tmlam_pkg::REG_CONFIG:    rd_data = s_q.config_r;
      tmlam_pkg::REG_RATE:      rd_data = s_q.rate;
      default: begin
        if (rd_addr[9:2] >= tmlam_pkg::REG_LIMIT_BASE &&
            rd_addr[9:2] <= tmlam_pkg::REG_LIMIT_LAST) begin
          rd_data = s_q.limit[3'(rd_addr[9:2] - tmlam_pkg::REG_LIMIT_BASE)];
        end
      end
    endcase
    if (!rd_ok) rd_data = 8'h00;
  end

  // next state for sequencer, registers, comparators and pins
  always_comb begin
    logic [3:0]  rate_c;
    logic [31:0] period;
    logic [9:0]  res, hi_lim, lo_lim;
    logic [7:0]  set_bits;
    logic        ext, standby, alarm_cond, trip_cond;
    rate_c     = 4'h0;
    period     = 32'h0000_0000;
    res        = 10'h000;
    hi_lim     = 10'h000;
    lo_lim     = 10'h000;
    set_bits   = 8'h00;
    alarm_cond = 1'b0;
    trip_cond  = 1'b0;
    s_d        = s_q;
    // (R12) control fields
    ext     = s_q.config_r[tmlam_pkg::CFG_EXT_RANGE];
    standby = s_q.config_r[tmlam_pkg::CFG_STANDBY];
    rate_c  = (s_q.rate[3:0] > tmlam_pkg::RATE_MAX) ? tmlam_pkg::RATE_MAX : s_q.rate[3:0];
    // higher rate code halves the wait between conversions
    period  = CONV_BASE_CYCLES << (tmlam_pkg::RATE_MAX - rate_c);
    s_d.conv_start = 1'b0;

    case (s_q.conv)
      ST_IDLE: begin
        if (s_q.timer != 32'h0000_0000) begin
          s_d.timer = s_q.timer - 32'h0000_0001;
        // (R1) self triggered start
        end else if (!standby) begin
          s_d.conv       = ST_START;
          s_d.conv_start = 1'b1;
        end
      end
      ST_START: s_d.conv = ST_WAIT;
      ST_WAIT: begin
        if (conv_done_i) begin
          res = encode(conv_data_i, ext);
          if (s_q.remote) begin
            // (R16) high byte frozen while locked
            if (!s_q.hi_lock) s_d.rem_hi = res[9:2];
            // (R3) remote result store
            s_d.rem_lo = {res[1:0], 6'h00};
            // (R4) remote limit compare
            hi_lim = {s_q.limit[tmlam_pkg::LIM_R_HIGH],
                      s_q.limit[tmlam_pkg::LIM_R_HIGH_FRAC][7:6]};
            lo_lim = {s_q.limit[tmlam_pkg::LIM_R_LOW],
                      s_q.limit[tmlam_pkg::LIM_R_LOW_FRAC][7:6]};
            set_bits[tmlam_pkg::ST_R_HIGH] = res > hi_lim;
            set_bits[tmlam_pkg::ST_R_LOW]  = res < lo_lim;
            s_d.trip_r = res[9:2] > s_q.limit[tmlam_pkg::LIM_R_TRIP];
            set_bits[tmlam_pkg::ST_R_TRIP] = s_d.trip_r;
          end else begin
            // (R3) local result store
            s_d.local_val = res[9:2];
            // (R4) local limit compare
            set_bits[tmlam_pkg::ST_L_HIGH] = res[9:2] > s_q.limit[tmlam_pkg::LIM_L_HIGH];
            set_bits[tmlam_pkg::ST_L_LOW]  = res[9:2] < s_q.limit[tmlam_pkg::LIM_L_LOW];
            s_d.trip_l = res[9:2] > s_q.limit[tmlam_pkg::LIM_L_TRIP];
            set_bits[tmlam_pkg::ST_L_TRIP] = s_d.trip_l;
          end
          // (R2) swap channel
          s_d.remote = ~s_q.remote;
          s_d.conv   = ST_IDLE;
          s_d.timer  = period;
        end
      end
      default: s_d.conv = ST_IDLE;
    endcase
    // (R7) sensor fault flag
    set_bits[tmlam_pkg::ST_FAULT] = fault_s;

    // register writes; read-only registers ignore writes
    if (wr_en && wr_ok && wr_byte0) begin
      // (R10) host programming
      case (wr_addr[9:2])
        tmlam_pkg::REG_CONFIG: s_d.config_r = wr_data[7:0];
        tmlam_pkg::REG_RATE:   s_d.rate     = wr_data[7:0];
        default: begin
          if (wr_addr[9:2] >= tmlam_pkg::REG_LIMIT_BASE &&
              wr_addr[9:2] <= tmlam_pkg::REG_LIMIT_LAST) begin
            s_d.limit[3'(wr_addr[9:2] - tmlam_pkg::REG_LIMIT_BASE)] = wr_data[7:0];
          end
        end
      endcase
    end

    // read side effects: clear flags, manage the high byte lock
    if (rd_en && rd_ok) begin
      if (rd_addr[9:2] == tmlam_pkg::REG_STATUS) s_d.status = 8'h00;
      // (R16) low read locks, high read unlocks
      if (rd_addr[9:2] == tmlam_pkg::REG_REMOTE_LO) s_d.hi_lock = 1'b1;
      if (rd_addr[9:2] == tmlam_pkg::REG_REMOTE_HI) s_d.hi_lock = 1'b0;
    end
    // (R5) sticky flags, a new event beats the read clear
    s_d.status = s_d.status | set_bits;
    s_d.status[tmlam_pkg::ST_BUSY] = (s_d.conv != ST_IDLE);

    // (R13) scl held low too long; off until enabled
    s_d.smb_to = 1'b0;
    if (scl_s || !s_q.config_r[tmlam_pkg::CFG_TIMEOUT_EN]) begin
      s_d.smb_cnt = 32'h0000_0000;
    end else if (s_q.smb_cnt < SMB_TIMEOUT_CYCLES) begin
      s_d.smb_cnt = s_q.smb_cnt + 32'h0000_0001;
      s_d.smb_to  = (s_d.smb_cnt == SMB_TIMEOUT_CYCLES);
    end

    // (R6) alarm from limit flags and the fault flag
    alarm_cond = |s_q.status[tmlam_pkg::ST_L_HIGH:tmlam_pkg::ST_FAULT];
    // (R8) trip comparator level
    trip_cond = s_q.trip_l | s_q.trip_r;
    s_d.trip_n = ~trip_cond;
    // (R9) pin acts as second trip
    if (s_q.config_r[tmlam_pkg::CFG_PIN_TRIP2]) begin
      s_d.alarm_n = ~trip_cond;
    end else begin
      // (R17) mask holds the pin released
      s_d.alarm_n = ~(alarm_cond & ~s_q.config_r[tmlam_pkg::CFG_ALARM_MASK]);
    end
  end

  // reset values are constants only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q          <= '0;
      s_q.conv     <= ST_IDLE;
      s_q.config_r <= tmlam_pkg::RST_CONFIG;
      s_q.rate     <= tmlam_pkg::RST_RATE;
      // slot 7 first; order must follow the slot numbers in the package
      s_q.limit    <= {tmlam_pkg::RST_FRAC, tmlam_pkg::RST_FRAC, tmlam_pkg::RST_TRIP,
                       tmlam_pkg::RST_TRIP, tmlam_pkg::RST_LOW, tmlam_pkg::RST_HIGH,
                       tmlam_pkg::RST_LOW, tmlam_pkg::RST_HIGH};
      s_q.alarm_n  <= 1'b1;
      s_q.trip_n   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // open-drain pins: enable high while pulling low
  assign alarm_n_o         = s_q.alarm_n;
  assign alarm_oe_o        = ~s_q.alarm_n;
  assign thermal_trip_n_o  = s_q.trip_n;
  assign thermal_trip_oe_o = ~s_q.trip_n;
  assign conv_start_o      = s_q.conv_start;
  assign conv_remote_o     = s_q.remote;
  assign smbus_timeout_o   = s_q.smb_to;
endmodule
`default_nettype wire

// file: testbench/tmlam_monitor.sv
// Purpose: port checks for the monitor core
// Assumes: one clock domain
// Notes:   bound from the bench top
`timescale 1ns/100ps
`default_nettype none
module tmlam_monitor (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        conv_start_o,
  input wire logic        conv_remote_o,
  input wire logic        smbus_scl_i,
  input wire logic        smbus_timeout_o,
  input wire logic        alarm_n_o,
  input wire logic        alarm_oe_o,
  input wire logic        thermal_trip_n_o,
  input wire logic        thermal_trip_oe_o
);
  // every check shares the core clock and reset
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o) else $error("start");
  a_chan_hold: assert property (conv_start_o |=> $stable(conv_remote_o)) else $error("chan");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_rvalid ##1 s_axi_rvalid) else $error("read late");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("d");
  a_trip_drive: assert property (thermal_trip_oe_o == !thermal_trip_n_o) else $error("trip");
  a_alarm_drive: assert property (alarm_oe_o == !alarm_n_o) else $error("alarm");
  a_timeout_low: assert property (smbus_timeout_o |->
    !$past(smbus_scl_i, 3) ##1 !smbus_timeout_o) else $error("timeout");
endmodule
`default_nettype wire

// file: testbench/tmlam_conv_model.sv
// Purpose: converter stand-in answering start strobes
// Assumes: answer delay from the bench, at least 3
// Notes:   data outside the done cycle is inverted
`timescale 1ns/100ps
`default_nettype none
module tmlam_conv_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic       remote_i,
  input  wire logic [9:0] loc_i,
  input  wire logic [9:0] rem_i,
  input  wire logic [3:0] lat_i,
  output logic            done_o,
  output logic [9:0]      data_o
);
  logic [3:0] cnt_q = 4'h0;
  // count down from each start, done strobes at one
  always @(posedge clk_i)
    cnt_q <= start_i ? lat_i : cnt_q - 4'(cnt_q != 4'h0);
  assign done_o = cnt_q == 4'h1;
  // answer for the channel the core selected
  assign data_o = (remote_i ? rem_i : loc_i) ^ {10{!done_o}};
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Purpose: self-checking bench for the monitor core
// Assumes: short conversion and timeout counts
// Notes:   bus tasks hold requests until taken
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [7:0] LIM [8] = '{8'h55, 8'h00, 8'h55, 8'h00, 8'h55, 8'h55, 8'h00, 8'h00};
  logic        clk_i = 1'h0, rst_n_i = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        sensor_fault_i = 1'h0, smbus_scl_i = 1'h1, scl_run = 1'h1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, lat = 4'h3;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        conv_start_o, conv_remote_o, conv_done_i, smbus_timeout_o;
  logic        alarm_n_o, alarm_oe_o, thermal_trip_n_o, thermal_trip_oe_o;
  logic [9:0]  conv_data_i, loc = 10'h078, rem = 10'h193;
  int          err_total = 0, checked = 0, cyc = 0, nst = 0, ntmo = 0;
  always #5 clk_i = ~clk_i;
  // bus clock runs free unless a test parks it
  always #40 if (scl_run) smbus_scl_i = ~smbus_scl_i;
  tmlam_top #(.CONV_BASE_CYCLES(4), .SMB_TIMEOUT_CYCLES(50)) u_dut (.*);
  tmlam_conv_model u_conv (.clk_i(clk_i), .start_i(conv_start_o), .remote_i(conv_remote_o),
    .loc_i(loc), .rem_i(rem), .lat_i(lat), .done_o(conv_done_i), .data_o(conv_data_i));
  // event counters and hang limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    nst <= nst + int'(conv_start_o);
    ntmo <= ntmo + int'(smbus_timeout_o);
    if (cyc == 30000) begin
      err_total++;
      summarize;
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= {22'h0, a, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, 2'h0);
  endtask
  // read a register; busy bit of status is live, so masked
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    s_axi_araddr <= {22'h0, a, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    rsp = s_axi_rresp;
    chk(s_axi_rdata & ~{24'h0, a == 8'h02, 7'h0}, e);
  endtask
  task automatic t_reset;
    rc(8'h03, 8'h00);
    rc(8'h04, 8'h08);
    for (int i = 0; i < 8; i++) rc(8'h05 + 8'(i), LIM[i]);
    wr(8'h0C, 8'hC0);
    rc(8'h0C, 8'hC0);
    rc(8'h0D, 8'h00);
    chk(rsp, 2'h2);
  endtask
  task automatic t_conv;
    wt(100);
    rc(8'h00, 8'h1E);
    chk(thermal_trip_n_o, 1'h0);
    chk(alarm_n_o, 1'h0);
    rc(8'h10, 8'hC0);
    rem <= 10'h0C8;
    wt(100);
    rc(8'h01, 8'h64);
    chk(thermal_trip_n_o, 1'h1);
    rc(8'h02, 8'h12);
    wt(100);
    chk(alarm_n_o, 1'h1);
  endtask
  task automatic t_cfg;
    rem <= 10'h193;
    wr(8'h03, 8'h80);
    wt(100);
    chk(alarm_n_o, 1'h1);
    rc(8'h02, 8'h12);
    wr(8'h03, 8'h20);
    wt(20);
    chk(alarm_n_o, 1'h0);
    rem <= 10'h0C8;
    wt(100);
    chk(alarm_n_o, 1'h1);
    wr(8'h03, 8'h00);
    rc(8'h02, 8'h12);
    rc(8'h02, 8'h00);
    sensor_fault_i <= 1'h1;
    wt(10);
    chk(alarm_n_o, 1'h0);
    sensor_fault_i <= 1'h0;
    rc(8'h02, 8'h04);
  endtask
  task automatic t_range;
    wr(8'h03, 8'h04);
    wt(100);
    rc(8'h00, 8'h5E);
    loc <= 10'h338;
    wt(100);
    rc(8'h00, 8'h18);
    wr(8'h03, 8'h00);
    wt(100);
    rc(8'h00, 8'h00);
    loc <= 10'h078;
  endtask
  task automatic t_standby;
    int n;
    lat <= 4'h9;
    wr(8'h04, 8'h0A);
    n = nst;
    wt(100);
    chk(nst - n > 4, 1'h1);
    wr(8'h03, 8'h40);
    wt(40);
    n = nst;
    wt(200);
    chk(nst - n, 0);
    wr(8'h03, 8'h00);
    lat <= 4'h3;
  endtask
  task automatic t_timeout;
    int n;
    scl_run = 1'h0;
    smbus_scl_i <= 1'h0;
    n = ntmo;
    wt(200);
    chk(ntmo - n, 0);
    wr(8'h03, 8'h01);
    wt(100);
    chk(ntmo != n, 1'h1);
    scl_run = 1'h1;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    wt(20);
    rst_n_i <= 1'h1;
    t_reset;
    t_conv;
    t_cfg;
    t_range;
    t_standby;
    t_timeout;
    summarize;
  end
endmodule
bind tmlam_top tmlam_monitor u_mon (.*);
`default_nettype wire
